// [trig_defines.svh]
// offsets, field positions, reset values and timing counts of the trigger control
`ifndef TRIG_DEFINES_SVH
`define TRIG_DEFINES_SVH
// register byte offsets
`define OFF_SW_TRIG     8'h00
`define OFF_STATUS      8'h04
`define OFF_ENC_IVAL    8'h08
`define OFF_BURST       8'h0c
`define OFF_FR_PERIOD   8'h40
`define OFF_SHUTTER     8'h44
// per-module block: base 0x10 * (module + 1), word index in bits 3:2
`define MOD_K_CFG       2'h0
`define MOD_K_TDLY      2'h1
`define MOD_K_EDLY      2'h2
`define MOD_K_OVR       2'h3
// status bit positions (ready bits sit at 2:0)
`define ST_EXPO_BIT     3
`define ST_ACQ_BIT      4
`define ST_RO_BIT       5
// selectable sources per module, bit index is the source code
`define MASK_BURST      5'h1b
`define MASK_FRAME      5'h0f
`define MASK_STOP       5'h01
// reset values
`define RST_BURST       16'h0001
`define RST_FR_PERIOD   24'h00_2710
`define RST_SHUTTER     24'h00_03e8
// timing: time delays, period and shutter count in microseconds
`define CLK_NS          40
`define US_NS           1000
`define US_CYC          ((`US_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// [trig_pkg.sv]
// types of the camera trigger control
package trig_pkg;
   `include "trig_defines.svh"
   typedef enum logic [2:0] {SRC_EXT, SRC_SW, SRC_FM, SRC_ENC, SRC_ONCE} src_t;
   typedef enum logic [1:0] {PH_IDLE, PH_STEP, PH_TIME} phase_t;
   // module configuration word, bit 0 is the enable
   typedef struct packed {
      logic [1:0] line;
      logic       edge_mode;
      logic       inv;
      src_t       src;
      logic       en;
   } mod_cfg_t;
   typedef struct packed {
      mod_cfg_t [2:0]       cfg;
      logic [2:0][15:0]     tdly;
      logic [2:0][15:0]     edly;
      logic [2:0][15:0]     ovr;
      logic [15:0]          ival;
      logic [15:0]          burst;
      logic [23:0]          period;
      logic [23:0]          shutter;
      logic [2:0]           sw;
      logic [2:0]           prev;
      logic [2:0][15:0]     ecnt;
      logic [2:0]           eonce;
      phase_t [2:0]         ph;
      logic [2:0][15:0]     dcnt;
      logic [4:0]           us_div;
      logic                 us_tick;
      logic                 acq;
      logic                 acq_out;
      logic [15:0]          left;
      logic                 expo;
      logic [23:0]          shut_cnt;
      logic                 ro_pend;
      logic [23:0]          fr_cnt;
      logic [2:0]           rdy;
      logic                 wr;
      logic [31:0]          rdata;
   } state_t;
endpackage

// [camera_trigger_control.sv]
// trigger control: burst start, frame begin and exposure stop modules with avalon registers
`timescale 1ns/1ps
`include "trig_defines.svh"
module camera_trigger_control (
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire logic [3:0]  ext_in,
   input  wire logic        fm_tick,
   input  wire logic        enc_step,
   input  wire logic        readout_done,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             burst_start_ready,
   output logic             frame_begin_ready,
   output logic             exposure_stop_ready,
   output logic             exposure_active,
   output logic             acquisition_active
);

   // ************************************************************
   // state and per-module source detection
   // ************************************************************
   // held state and its next value
   trig_pkg::state_t s;
   trig_pkg::state_t n;

   // per-module source signals
   logic [2:0]       lvl;
   logic [2:0]       pulse;
   logic [2:0]       req;
   logic [2:0]       ovr_evt;
   logic [2:0]       ehit;

   // selected source per module turned into request and overrun events
   for (genvar g = 0; g < 3; g++) begin : g_src
      localparam logic [4:0] MASK = (g == 0) ? `MASK_BURST : ((g == 1) ? `MASK_FRAME : `MASK_STOP);
      trig_pkg::mod_cfg_t c;
      logic               ok;
      logic               esel;
      logic               sp;
      logic               sr;
      logic               frf;

      // configuration of this module, codes past the last source are never legal
      assign c = s.cfg[g];
      assign ok = (c.src <= trig_pkg::SRC_ONCE) && MASK[c.src];
      // selected line after the optional inversion
      assign lvl[g] = ext_in[c.line] ^ c.inv;
      // encoder sources share the interval counter
      assign esel = (c.src == trig_pkg::SRC_ENC) || (c.src == trig_pkg::SRC_ONCE);
      // interval reached on this step, single shot only the first time
      assign ehit[g] = enc_step && esel && (s.ival != 16'h0000) && ((s.ecnt[g] + 16'h0001) == s.ival)
                       && !((c.src == trig_pkg::SRC_ONCE) && s.eonce[g]);
      assign sp = (c.src == trig_pkg::SRC_EXT) ? (lvl[g] & ~s.prev[g]) :
                  (c.src == trig_pkg::SRC_SW)  ? s.sw[g] :
                  (c.src == trig_pkg::SRC_FM)  ? fm_tick : ehit[g];
      // level mode keeps requesting while the line stays active
      assign sr = ((c.src == trig_pkg::SRC_EXT) && !c.edge_mode) ? lvl[g] : sp;
      // free-running frame source when frame begin is disabled
      assign frf = (g == 1) && !c.en && s.us_tick && (s.fr_cnt == 24'h00_0000)
                   && (s.period != 24'h00_0000);

      // one-cycle strobe for the overrun count, held request for acceptance
      assign pulse[g] = c.en & ok & sp;
      assign req[g] = (c.en & ok & sr) | frf;
      assign ovr_evt[g] = pulse[g] & ~s.rdy[g];
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      // working values of this cycle
      logic [2:0]  fire;
      logic        acq_act;
      logic        end_now;
      logic        hit;
      logic [31:0] rv;
      logic [31:0] bm;
      logic [31:0] wv;
      logic [1:0]  mi;

      // defaults for every path
      fire = 3'h0;
      acq_act = 1'b0;
      end_now = 1'b0;
      hit = 1'b0;
      rv = 32'h0000_0000;
      mi = 2'h0;
      wv = 32'h0000_0000;
      // byte lanes enabled by the master
      bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

      // hold the state, one-cycle strobes cleared
      n = s;
      n.sw = 3'h0;
      n.prev = lvl;
      // microsecond tick for delays, shutter and free-run period
      n.us_tick = (s.us_div == 5'(`US_CYC - 1));
      n.us_div = n.us_tick ? 5'h00 : s.us_div + 5'h01;

      for (int m = 0; m < 3; m++) begin
         // encoder interval counters
         if (s.cfg[m].en && ((s.cfg[m].src == trig_pkg::SRC_ENC) || (s.cfg[m].src == trig_pkg::SRC_ONCE))) begin
            if (ehit[m]) begin
               n.ecnt[m] = 16'h0000;
               if (s.cfg[m].src == trig_pkg::SRC_ONCE) begin
                  n.eonce[m] = 1'b1;
               end
            end else if (enc_step && !s.eonce[m]) begin
               n.ecnt[m] = s.ecnt[m] + 16'h0001;
            end
         end else begin
            n.ecnt[m] = 16'h0000;
            n.eonce[m] = 1'b0;
         end

         // refused strobe bumps the read-only overrun count
         if (ovr_evt[m]) begin
            n.ovr[m] = s.ovr[m] + 16'h0001;
         end

         // accept, step delay, time delay, fire
         case (s.ph[m])
            trig_pkg::PH_IDLE: begin
               // take a request only while ready
               if (req[m] && s.rdy[m]) begin
                  if ((m < 2) && (s.edly[m] != 16'h0000)) begin
                     n.ph[m] = trig_pkg::PH_STEP;
                     n.dcnt[m] = s.edly[m];
                  end else if (s.tdly[m] != 16'h0000) begin
                     n.ph[m] = trig_pkg::PH_TIME;
                     n.dcnt[m] = s.tdly[m];
                  end else begin
                     fire[m] = 1'b1;
                  end
               end
            end
            trig_pkg::PH_STEP: begin
               // count encoder steps down
               if (enc_step) begin
                  if (s.dcnt[m] > 16'h0001) begin
                     n.dcnt[m] = s.dcnt[m] - 16'h0001;
                  end else if (s.tdly[m] != 16'h0000) begin
                     n.ph[m] = trig_pkg::PH_TIME;
                     n.dcnt[m] = s.tdly[m];
                  end else begin
                     n.ph[m] = trig_pkg::PH_IDLE;
                     fire[m] = 1'b1;
                  end
               end
            end
            trig_pkg::PH_TIME: begin
               // count microsecond ticks down
               if (s.us_tick) begin
                  if (s.dcnt[m] > 16'h0001) begin
                     n.dcnt[m] = s.dcnt[m] - 16'h0001;
                  end else begin
                     n.ph[m] = trig_pkg::PH_IDLE;
                     fire[m] = 1'b1;
                  end
               end
            end
            default: begin
               // unused phase code falls back to idle
               n.ph[m] = trig_pkg::PH_IDLE;
            end
         endcase
      end

      // ************************************************************
      // burst, exposure and free-run timing
      // ************************************************************
      // burst gating
      if (fire[0] && (s.burst != 16'h0000)) begin
         n.acq = 1'b1;
         n.left = s.burst;
      end

      // acquisition window seen by the frame module
      acq_act = !s.cfg[0].en || s.acq;

      // exposure start, one frame of the burst consumed
      if (fire[1] && acq_act && !s.expo) begin
         n.expo = 1'b1;
         n.shut_cnt = s.shutter;
         if (s.cfg[0].en && (s.left != 16'h0000)) begin
            n.left = s.left - 16'h0001;
         end
      end

      // exposure end by stop module or shutter count
      if (s.cfg[2].en) begin
         end_now = s.expo && fire[2];
      end else if (s.expo && s.us_tick) begin
         end_now = (s.shut_cnt <= 24'h00_0001);
         n.shut_cnt = s.shut_cnt - 24'h00_0001;
      end

      // readout finished; an exposure end in the same cycle still sets pending
      if (readout_done) begin
         n.ro_pend = 1'b0;
      end
      if (end_now) begin
         n.expo = 1'b0;
         n.ro_pend = 1'b1;
         if (s.cfg[0].en && (s.left == 16'h0000)) begin
            n.acq = 1'b0;
         end
      end

      // free-run period counter
      if (s.cfg[1].en) begin
         n.fr_cnt = 24'h00_0000;
      end else if (s.us_tick) begin
         n.fr_cnt = (s.fr_cnt == 24'h00_0000) ? s.period - 24'h00_0001 : s.fr_cnt - 24'h00_0001;
      end

      // ************************************************************
      // register bus
      // ************************************************************
      // register read value
      if ((avs_address[7:4] >= 4'h1) && (avs_address[7:4] <= 4'h3)) begin
         // per-module block, word chosen by address bits 3:2
         mi = 2'(avs_address[7:4] - 4'h1);
         hit = 1'b1;
         case (avs_address[3:2])
            `MOD_K_CFG:  rv = {24'h00_0000, s.cfg[mi]};
            `MOD_K_TDLY: rv = {16'h0000, s.tdly[mi]};
            `MOD_K_EDLY: rv = {16'h0000, s.edly[mi]};
            default:     rv = {16'h0000, s.ovr[mi]};
         endcase
      end else begin
         // global registers
         case (avs_address)
            `OFF_SW_TRIG:   rv = 32'h0000_0000;
            `OFF_STATUS:    rv = {26'h000_0000, s.ro_pend, s.acq, s.expo, s.rdy};
            `OFF_ENC_IVAL:  rv = {16'h0000, s.ival};
            `OFF_BURST:     rv = {16'h0000, s.burst};
            `OFF_FR_PERIOD: rv = {8'h00, s.period};
            `OFF_SHUTTER:   rv = {8'h00, s.shutter};
            default:        rv = 32'h0000_0000;
         endcase
      end

      // write value: unselected bytes keep their old contents
      wv = (rv & ~bm) | (avs_writedata & bm);

      // avalon slave: answer one cycle after the request is seen
      if (s.wr && (avs_read || avs_write)) begin
         n.wr = 1'b0;
         n.rdata = avs_read ? rv : 32'h0000_0000;
      end else if (!s.wr) begin
         // answer cycle: writes land at its closing edge, waitrequest rises again
         n.wr = 1'b1;
         if (avs_write && hit) begin
            case (avs_address[3:2])
               `MOD_K_CFG:  n.cfg[mi] = trig_pkg::mod_cfg_t'(wv[7:0]);
               `MOD_K_TDLY: n.tdly[mi] = wv[15:0];
               `MOD_K_EDLY: n.edly[mi] = wv[15:0];
               default:     n.ovr[mi] = n.ovr[mi]; // read only
            endcase
         end else if (avs_write) begin
            // global registers; status and unmapped words ignore writes
            case (avs_address)
               `OFF_SW_TRIG:   n.sw = avs_byteenable[0] ? avs_writedata[2:0] : 3'h0;
               `OFF_ENC_IVAL:  n.ival = wv[15:0];
               `OFF_BURST:     n.burst = wv[15:0];
               `OFF_FR_PERIOD: n.period = wv[23:0];
               `OFF_SHUTTER:   n.shutter = wv[23:0];
               default:        n.wr = 1'b1;
            endcase
         end
      end

      // ************************************************************
      // ready flags and acquisition window
      // ************************************************************
      // ready flags from the next state
      n.rdy[0] = n.cfg[0].en && !n.acq && (n.ph[0] == trig_pkg::PH_IDLE);
      n.rdy[1] = (n.ph[1] == trig_pkg::PH_IDLE) && !n.expo && !n.ro_pend && (!n.cfg[0].en || n.acq);
      n.rdy[2] = n.cfg[2].en && n.expo && (n.ph[2] == trig_pkg::PH_IDLE);
      // acquisition window registered for its output pin
      n.acq_out = !n.cfg[0].en || n.acq;
   end

   // ************************************************************
   // state register
   // ************************************************************
   // the whole state in one register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
         // fields whose reset value is not zero
         s.burst <= `RST_BURST;
         s.period <= `RST_FR_PERIOD;
         s.shutter <= `RST_SHUTTER;
         s.wr <= 1'b1;
         s.acq_out <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // outputs straight from the state register
   assign avs_readdata = s.rdata;
   assign avs_waitrequest = s.wr;
   assign burst_start_ready = s.rdy[0];
   assign frame_begin_ready = s.rdy[1];
   assign exposure_stop_ready = s.rdy[2];
   assign exposure_active = s.expo;
   assign acquisition_active = s.acq_out;

endmodule

// [trig_checker_sva.sv]
// port assertions of the camera trigger control
`timescale 1ns/1ps
module trig_checker (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic frame_begin_ready,
   input wire logic exposure_stop_ready,
   input wire logic exposure_active,
   input wire logic acquisition_active
);
   // ********
   // properties on the bus, readies and exposure
   // ********
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered");
   AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer longer than one cycle");
   AST_BUS_QUIET: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
      else $error("answer without request");
   AST_EXPO_NOT_READY: assert property (exposure_active |-> !frame_begin_ready)
      else $error("frame ready during exposure");
   AST_READY_IN_ACQ: assert property (frame_begin_ready |-> acquisition_active)
      else $error("frame ready outside acquisition");
   AST_START_IN_ACQ: assert property ($rose(exposure_active) |-> $past(acquisition_active))
      else $error("exposure outside acquisition");
   AST_REARM: assert property ($rose(frame_begin_ready) |-> !exposure_active && !$past(exposure_active))
      else $error("frame ready back while exposing");
   AST_STOP_READY: assert property (exposure_stop_ready |-> exposure_active || $past(exposure_active))
      else $error("stop ready without exposure");
endmodule
bind camera_trigger_control trig_checker i_trig_checker (
   .clk_sys(clk_sys), .arst_n(arst_n), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .frame_begin_ready(frame_begin_ready),
   .exposure_stop_ready(exposure_stop_ready), .exposure_active(exposure_active),
   .acquisition_active(acquisition_active));

// [trig_far_side.sv]
// model of trigger lines, encoder, multiplier and sensor readout
`timescale 1ns/1ps
module trig_far_side (
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic       exposure_active,
   input  wire logic [3:0] lines_req,
   input  wire logic       step_req,
   input  wire logic       fm_req,
   input  wire logic [4:0] ro_wait,
   output logic [3:0]      ext_in,
   output logic            enc_step,
   output logic            fm_tick,
   output logic            readout_done
);
   logic       expo_q;
   logic [5:0] ro_cnt;
   // registered lines and one-cycle pulses, readout ends ro_wait + 2 cycles after exposure
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ext_in <= 4'h0;
         enc_step <= 1'b0;
         fm_tick <= 1'b0;
         expo_q <= 1'b0;
         ro_cnt <= 6'h00;
         readout_done <= 1'b0;
      end else begin
         ext_in <= lines_req;
         enc_step <= step_req;
         fm_tick <= fm_req;
         expo_q <= exposure_active;
         readout_done <= (ro_cnt == 6'h01);
         if (expo_q && !exposure_active) begin
            ro_cnt <= {1'b0, ro_wait} + 6'h01;
         end else if (ro_cnt != 6'h00) begin
            ro_cnt <= ro_cnt - 6'h01;
         end
      end
   end
endmodule

// [tb_top.sv]
// self-checking bench of the camera trigger control
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t got %h want %h", $time, g, e); end end
module tb_top;
   logic        clk_sys = 1'b0;
   logic        arst_n = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest, burst_start_ready, frame_begin_ready, exposure_stop_ready;
   logic        exposure_active, acquisition_active, enc_step, fm_tick, readout_done;
   logic [3:0]  ext_in;
   logic [3:0]  lines_req = 4'h0;
   logic        step_req = 1'b0;
   logic        fm_req = 1'b0;
   logic [4:0]  ro_wait = 5'h01;
   logic [15:0] expq[$];
   logic [31:0] seed = 32'h0000_0008;
   int          failures = 0;
   int          n_tests = 0;
   int          n;
   // ********
   // design, far side and clock
   // ********
   camera_trigger_control i_camera_trigger_control (.clk_sys(clk_sys), .arst_n(arst_n), .ext_in(ext_in),
      .fm_tick(fm_tick), .enc_step(enc_step), .readout_done(readout_done), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .burst_start_ready(burst_start_ready),
      .frame_begin_ready(frame_begin_ready), .exposure_stop_ready(exposure_stop_ready),
      .exposure_active(exposure_active), .acquisition_active(acquisition_active));
   trig_far_side i_trig_far_side (.clk_sys(clk_sys), .arst_n(arst_n), .exposure_active(exposure_active),
      .lines_req(lines_req), .step_req(step_req), .fm_req(fm_req), .ro_wait(ro_wait), .ext_in(ext_in),
      .enc_step(enc_step), .fm_tick(fm_tick), .readout_done(readout_done));
   always #20 clk_sys = ~clk_sys;
   // pins by index: 0 burst ready, 1 frame ready, 2 stop ready, 3 exposing, 4 acquiring
   function automatic logic pin(input int k);
      logic [4:0] p;
      p = {acquisition_active, exposure_active, exposure_stop_ready, frame_begin_ready, burst_start_ready};
      return p[k];
   endfunction
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic rd, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_read <= rd;
      avs_write <= !rd;
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(1'b0, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      expq.push_back(e);
      bus(1'b1, a, 16'h0000);
   endtask
   task automatic wait_pin(input int k, input logic v, input int lim);
      int c;
      c = 0;
      while (pin(k) !== v && c < lim) begin
         @(posedge clk_sys);
         c++;
      end
      `CHK(pin(k), v)
   endtask
   task automatic pulse(input logic fm, input int cnt);
      repeat (cnt) begin
         step_req <= !fm;
         fm_req <= fm;
         @(posedge clk_sys);
         step_req <= 1'b0;
         fm_req <= 1'b0;
         @(posedge clk_sys);
      end
   endtask
   task automatic frame_done;
      wait_pin(3, 1'b0, 200);
      wait_pin(1, 1'b1, 60);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // read data compared against the oldest note
   always @(posedge clk_sys) begin
      if (arst_n && avs_read && avs_waitrequest === 1'b0) begin
         if (expq.size() == 0) failures++;
         else `CHK(avs_readdata, {16'h0000, expq.pop_front()})
      end
   end
   // watchdog
   initial begin
      #(40 * 30000);
      failures++;
      wrap_up();
   end
   // main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      wr(8'h44, 16'h0004);
      wr(8'h40, 16'h0006);
      rd(8'h0c, 16'h0001);
      rd(8'h80, 16'h0000);
      wait_pin(4, 1'b1, 0);
      wait_pin(3, 1'b1, 1000);
      frame_done();
      wr(8'h20, 16'h0003);
      frame_done();
      wr(8'h00, 16'h0002);
      wait_pin(3, 1'b1, 6);
      wait_pin(1, 1'b0, 0);
      wr(8'h00, 16'h0002);
      frame_done();
      rd(8'h2c, 16'h0001);
      wr(8'h2c, 16'h0000);
      rd(8'h2c, 16'h0001);
      wr(8'h24, 16'h0003);
      wr(8'h00, 16'h0002);
      wait_pin(1, 1'b0, 6);
      repeat (40) @(posedge clk_sys);
      wait_pin(3, 1'b0, 0);
      wait_pin(3, 1'b1, 60);
      frame_done();
      wr(8'h24, 16'h0000);
      lines_req <= 4'h4;
      ro_wait <= 5'h1f;
      wr(8'h20, 16'h00b1);
      lines_req <= 4'h0;
      wait_pin(3, 1'b1, 6);
      frame_done();
      wr(8'h20, 16'h00c1);
      lines_req <= 4'h8;
      wait_pin(3, 1'b1, 6);
      frame_done();
      wait_pin(3, 1'b1, 6);
      lines_req <= 4'h0;
      frame_done();
      wr(8'h44, 16'h0030);
      wr(8'h30, 16'h0061);
      wr(8'h20, 16'h0003);
      wr(8'h00, 16'h0002);
      wait_pin(2, 1'b1, 8);
      lines_req <= 4'h2;
      wait_pin(3, 1'b0, 6);
      frame_done();
      lines_req <= 4'h0;
      wr(8'h30, 16'h0000);
      wr(8'h44, 16'h0004);
      seed = xs(seed);
      n = 2 + int'(seed[1:0]);
      wr(8'h08, 16'(n));
      wr(8'h20, 16'h0007);
      pulse(1'b0, n - 1);
      wait_pin(3, 1'b0, 0);
      pulse(1'b0, 1);
      wait_pin(3, 1'b1, 6);
      frame_done();
      wr(8'h28, 16'h0002);
      wr(8'h20, 16'h0003);
      wr(8'h00, 16'h0002);
      pulse(1'b0, 1);
      wait_pin(3, 1'b0, 0);
      pulse(1'b0, 1);
      wait_pin(3, 1'b1, 6);
      frame_done();
      wr(8'h28, 16'h0000);
      wr(8'h20, 16'h0005);
      pulse(1'b1, 1);
      wait_pin(3, 1'b1, 6);
      frame_done();
      wr(8'h20, 16'h0009);
      pulse(1'b0, n);
      repeat (4) @(posedge clk_sys);
      wait_pin(3, 1'b0, 0);
      wr(8'h20, 16'h0003);
      wr(8'h0c, 16'h0002);
      wr(8'h10, 16'h0003);
      wait_pin(4, 1'b0, 2);
      wait_pin(0, 1'b1, 4);
      wait_pin(1, 1'b0, 4);
      wr(8'h00, 16'h0001);
      wait_pin(4, 1'b1, 6);
      for (int i = 0; i < 2; i++) begin
         wait_pin(1, 1'b1, 60);
         wr(8'h00, 16'h0002);
         wait_pin(3, 1'b1, 6);
         wait_pin(3, 1'b0, 200);
      end
      wait_pin(4, 1'b0, 2);
      wr(8'h0c, 16'h0001);
      wr(8'h10, 16'h0009);
      pulse(1'b0, n);
      wait_pin(4, 1'b1, 6);
      frame_done();
      wr(8'h00, 16'h0002);
      wait_pin(3, 1'b1, 6);
      wait_pin(3, 1'b0, 200);
      pulse(1'b0, n);
      repeat (4) @(posedge clk_sys);
      wait_pin(4, 1'b0, 0);
      wrap_up();
   end
endmodule
